//--- inc/ibt_consts.svh
`ifndef IBT_CONSTS_SVH
`define IBT_CONSTS_SVH

// register bus geometry
`define IBT_ADDR_W          16
`define IBT_DATA_W          8

// register addresses
`define IBT_ADDR_BAND       16'h009D
`define IBT_ADDR_FINE       16'h009E
`define IBT_ADDR_COARSE     16'h009F
`define IBT_ADDR_SRC        16'hFE00
`define IBT_ADDR_DIV        16'hFE01
`define IBT_ADDR_STATUS     16'hFE08

// field layout
`define IBT_BAND_W          2
`define IBT_SRC_W           2
`define IBT_TRIM_W          8
`define IBT_DIV_W           8
`define IBT_FINE_BIT        0
`define IBT_ST_LOADED       0
`define IBT_ST_OVER         1
`define IBT_ST_SYSLVL       2

// reset values before the stored values are loaded
`define IBT_RST_BYTE        8'h00
`define IBT_RST_BAND        2'h0
`define IBT_RST_SRC         2'h0

// master source codes
`define IBT_SRC_HIRC        2'h0
`define IBT_SRC_XTAL        2'h1
`define IBT_SRC_LIRC        2'h3

// band centres and top band trim span, in kHz
`define IBT_CTR_B0_KHZ      32'd6000
`define IBT_CTR_B1_KHZ      32'd10000
`define IBT_CTR_B2_KHZ      32'd27000
`define IBT_CTR_B3_KHZ      32'd44000
`define IBT_SPAN_LO_KHZ     32'd29000
`define IBT_SPAN_HI_KHZ     32'd55000
`define IBT_LIMIT_KHZ       16'd45000
`define IBT_TRIM_SHIFT      8
`define IBT_FINE_SHIFT      9
`define IBT_FREQ_W          16

`endif

//--- inc/ibt_pkg.sv
`default_nettype none
`include "ibt_consts.svh"

package ibt_pkg;
  typedef logic [`IBT_ADDR_W-1:0] ibt_addr_t;
  typedef logic [`IBT_DATA_W-1:0] ibt_byte_t;
  typedef logic [`IBT_FREQ_W-1:0] ibt_freq_t;
  // stored-value load sequence after reset
  typedef enum logic [0:0] {
    IBT_LD_PEND,
    IBT_LD_DONE
  } ibt_ld_state_e;
endpackage

`default_nettype wire

//--- inc/ibt_clk_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "ibt_consts.svh"

// master tick, divisor and divided clock between the block's modules
interface ibt_clk_if;
  logic [`IBT_SRC_W-1:0] source;
  logic [`IBT_DIV_W-1:0] divisor;
  logic                  master_tick;
  logic                  sys_tick;
  logic                  sys_level;

  modport src (input source, output master_tick);
  modport div (input master_tick, input divisor,
               output sys_tick, output sys_level);
  modport top (output source, output divisor,
               input master_tick, input sys_tick, input sys_level);
endinterface

`default_nettype wire

//--- design/ibt_src_sel.sv
`timescale 1ns/1ps
`default_nettype none
`include "ibt_consts.svh"

module ibt_src_sel
  import ibt_pkg::*;
(
  input  wire logic i_core_clk,
  input  wire logic i_arst_n,
  input  wire logic i_xtal_clk_pin,
  input  wire logic i_lirc_clk_pin,
  ibt_clk_if.src    clk_if
);
  logic [2:0] xtal_reg;
  logic [2:0] xtal_next;
  logic [2:0] lirc_reg;
  logic [2:0] lirc_next;
  logic       tick_reg;
  logic       tick_next;

  // two-stage synchronisers plus a history stage for edge detection
  always_comb begin
    xtal_next = {xtal_reg[1:0], i_xtal_clk_pin};
    lirc_next = {lirc_reg[1:0], i_lirc_clk_pin};
    tick_next = 1'b0;
    unique case (clk_if.source)
      `IBT_SRC_HIRC: tick_next = 1'b1;
      `IBT_SRC_XTAL: tick_next = xtal_reg[1] & ~xtal_reg[2];
      `IBT_SRC_LIRC: tick_next = lirc_reg[1] & ~lirc_reg[2];
      default:       tick_next = 1'b0; // reserved code stops the master
    endcase
  end

  // register the synchronisers and the master tick
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      xtal_reg <= 3'h0;
      lirc_reg <= 3'h0;
      tick_reg <= 1'b0;
    end else begin
      xtal_reg <= xtal_next;
      lirc_reg <= lirc_next;
      tick_reg <= tick_next;
    end
  end

  assign clk_if.master_tick = tick_reg;
endmodule

`default_nettype wire

//--- design/ibt_div.sv
`timescale 1ns/1ps
`default_nettype none
`include "ibt_consts.svh"

module ibt_div
  import ibt_pkg::*;
#(
  parameter int DIV_W = `IBT_DIV_W
) (
  input  wire logic i_core_clk,
  input  wire logic i_arst_n,
  ibt_clk_if.div    clk_if
);
  generate
    if (DIV_W != `IBT_DIV_W) begin : g_chk
      $error("ibt_div: DIV_W must match the divider field width");
    end
  endgenerate

  logic [DIV_W-1:0] cnt_reg;
  logic [DIV_W-1:0] cnt_next;
  logic             tick_reg;
  logic             tick_next;
  logic             lvl_reg;
  logic             lvl_next;
  logic [DIV_W-1:0] last;

  // count master ticks; 0 and 1 both pass every tick
  always_comb begin
    last      = (clk_if.divisor > DIV_W'(1)) ?
                DIV_W'(clk_if.divisor - DIV_W'(1)) : '0;
    cnt_next  = cnt_reg;
    tick_next = 1'b0;
    lvl_next  = lvl_reg;
    if (clk_if.master_tick) begin
      if (cnt_reg >= last) begin
        cnt_next  = '0;
        tick_next = 1'b1;
        lvl_next  = ~lvl_reg;
      end else begin
        cnt_next  = DIV_W'(cnt_reg + DIV_W'(1));
      end
    end
  end

  // register the divider state
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
      lvl_reg  <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
      lvl_reg  <= lvl_next;
    end
  end

  assign clk_if.sys_tick  = tick_reg;
  assign clk_if.sys_level = lvl_reg;
endmodule

`default_nettype wire

//--- design/ibt_top.sv
// Overview of operation
// - two-bit band code picks centre 6, 10, 27 or 44 MHz.
// - eight-bit coarse trim, 256 steps, each about 0.24 percent faster.
// - single fine trim bit at bit 0 adds a small extra adjustment.
// - system clock is master clock over divider; 0 and 1 mean no division.
// - in the top band the trim spans roughly 29 to 55 MHz.
// - source code 00 internal oscillator, 01 external, 11 low-speed 32 kHz.
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "ibt_consts.svh"

module ibt_top
  import ibt_pkg::*;
(
  input  wire logic                   i_core_clk,
  input  wire logic                   i_arst_n,
  input  wire logic [`IBT_ADDR_W-1:0] i_addr,
  input  wire logic [`IBT_DATA_W-1:0] i_wr_data,
  input  wire logic                   i_wr_stb,
  input  wire logic                   i_rd_stb,
  output var  logic [`IBT_DATA_W-1:0] o_rd_data,
  input  wire logic [`IBT_BAND_W-1:0] i_prog_band,
  input  wire logic [`IBT_TRIM_W-1:0] i_prog_coarse,
  input  wire logic                   i_prog_fine,
  input  wire logic [`IBT_DIV_W-1:0]  i_prog_div,
  input  wire logic                   i_xtal_clk_pin,
  input  wire logic                   i_lirc_clk_pin,
  output var  logic [`IBT_BAND_W-1:0] o_osc_band_select,
  output var  logic [`IBT_TRIM_W-1:0] o_osc_coarse_trim,
  output var  logic                   o_osc_fine_trim,
  output var  logic [`IBT_SRC_W-1:0]  o_master_source_select,
  output var  logic                   o_master_tick,
  output var  logic                   o_divided_system_clock,
  output var  logic [`IBT_FREQ_W-1:0] o_freq_est_khz,
  output var  logic                   o_over_limit
);

  // register state
  logic [`IBT_BAND_W-1:0] band_reg;
  logic [`IBT_BAND_W-1:0] band_next;
  logic [`IBT_TRIM_W-1:0] coarse_reg;
  logic [`IBT_TRIM_W-1:0] coarse_next;
  logic                   fine_reg;
  logic                   fine_next;
  logic [`IBT_DIV_W-1:0]  div_reg;
  logic [`IBT_DIV_W-1:0]  div_next;
  logic [`IBT_SRC_W-1:0]  src_reg;
  logic [`IBT_SRC_W-1:0]  src_next;
  ibt_ld_state_e          ld_reg;
  ibt_ld_state_e          ld_next;

  // read port state
  ibt_byte_t              rd_reg;
  ibt_byte_t              rd_next;

  // frequency estimate state
  ibt_freq_t              freq_reg;
  ibt_freq_t              freq_next;
  logic                   over_reg;
  logic                   over_next;

  // write decode
  logic                   wr_band;
  logic                   wr_fine;
  logic                   wr_coarse;
  logic                   wr_div;
  logic                   wr_src;

  ibt_clk_if clk_if ();

  // address match used by both the write and the read paths
  function automatic logic hit(input ibt_addr_t a, input ibt_addr_t reg_a);
    hit = (a == reg_a);
  endfunction

  // band centre in kHz for a band code
  function automatic logic [31:0] band_ctr(
    input logic [`IBT_BAND_W-1:0] b
  );
    unique case (b)
      2'h0:    band_ctr = `IBT_CTR_B0_KHZ;
      2'h1:    band_ctr = `IBT_CTR_B1_KHZ;
      2'h2:    band_ctr = `IBT_CTR_B2_KHZ;
      default: band_ctr = `IBT_CTR_B3_KHZ;
    endcase
  endfunction

  // lower edge of the trim span, scaled from the top band
  function automatic logic [31:0] span_lo(
    input logic [`IBT_BAND_W-1:0] b
  );
    span_lo = (band_ctr(b) * `IBT_SPAN_LO_KHZ) / `IBT_CTR_B3_KHZ;
  endfunction

  // upper edge of the trim span, scaled from the top band
  function automatic logic [31:0] span_hi(
    input logic [`IBT_BAND_W-1:0] b
  );
    span_hi = (band_ctr(b) * `IBT_SPAN_HI_KHZ) / `IBT_CTR_B3_KHZ;
  endfunction

  // source and divider modules
  ibt_src_sel u_src (
    .i_core_clk     (i_core_clk),
    .i_arst_n       (i_arst_n),
    .i_xtal_clk_pin (i_xtal_clk_pin),
    .i_lirc_clk_pin (i_lirc_clk_pin),
    .clk_if         (clk_if.src)
  );

  ibt_div #(
    .DIV_W (`IBT_DIV_W)
  ) u_div (
    .i_core_clk (i_core_clk),
    .i_arst_n   (i_arst_n),
    .clk_if     (clk_if.div)
  );

  assign clk_if.source  = src_reg;
  assign clk_if.divisor = div_reg;

  // write strobes per register
  always_comb begin
    wr_band   = i_wr_stb & hit(i_addr, `IBT_ADDR_BAND);
    wr_fine   = i_wr_stb & hit(i_addr, `IBT_ADDR_FINE);
    wr_coarse = i_wr_stb & hit(i_addr, `IBT_ADDR_COARSE);
    wr_div    = i_wr_stb & hit(i_addr, `IBT_ADDR_DIV);
    wr_src    = i_wr_stb & hit(i_addr, `IBT_ADDR_SRC);
  end

  // next register values: stored load first, then software writes
  always_comb begin
    band_next   = band_reg;
    coarse_next = coarse_reg;
    fine_next   = fine_reg;
    div_next    = div_reg;
    src_next    = src_reg;
    ld_next     = ld_reg;
    unique case (ld_reg)
      IBT_LD_PEND: begin
        band_next   = i_prog_band;
        coarse_next = i_prog_coarse;
        fine_next   = i_prog_fine;
        div_next    = i_prog_div;
        ld_next     = IBT_LD_DONE;
      end
      IBT_LD_DONE: begin
        if (wr_band) begin
          band_next = i_wr_data[`IBT_BAND_W-1:0];
        end
        if (wr_coarse) begin
          coarse_next = i_wr_data[`IBT_TRIM_W-1:0];
        end
        if (wr_fine) begin
          fine_next = i_wr_data[`IBT_FINE_BIT];
        end
        if (wr_div) begin
          div_next = i_wr_data[`IBT_DIV_W-1:0];
        end
        if (wr_src) begin
          src_next = i_wr_data[`IBT_SRC_W-1:0];
        end
      end
    endcase
  end

  // register file flops
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      band_reg   <= `IBT_RST_BAND;
      coarse_reg <= `IBT_RST_BYTE;
      fine_reg   <= 1'b0;
      div_reg    <= `IBT_RST_BYTE;
      src_reg    <= `IBT_RST_SRC;
      ld_reg     <= IBT_LD_PEND;
    end else begin
      band_reg   <= band_next;
      coarse_reg <= coarse_next;
      fine_reg   <= fine_next;
      div_reg    <= div_next;
      src_reg    <= src_next;
      ld_reg     <= ld_next;
    end
  end

  // read mux: data stand only in the cycle after the strobe
  always_comb begin
    rd_next = `IBT_RST_BYTE;
    if (i_rd_stb) begin
      if (hit(i_addr, `IBT_ADDR_BAND)) begin
        rd_next = ibt_byte_t'(band_reg);
      end else if (hit(i_addr, `IBT_ADDR_FINE)) begin
        rd_next = ibt_byte_t'(fine_reg);
      end else if (hit(i_addr, `IBT_ADDR_COARSE)) begin
        rd_next = coarse_reg;
      end else if (hit(i_addr, `IBT_ADDR_DIV)) begin
        rd_next = div_reg;
      end else if (hit(i_addr, `IBT_ADDR_SRC)) begin
        rd_next = ibt_byte_t'(src_reg);
      end else if (hit(i_addr, `IBT_ADDR_STATUS)) begin
        rd_next[`IBT_ST_LOADED] = (ld_reg == IBT_LD_DONE);
        rd_next[`IBT_ST_OVER]   = over_reg;
        rd_next[`IBT_ST_SYSLVL] = clk_if.sys_level;
      end
    end
  end

  // read data flop
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd_reg <= `IBT_RST_BYTE;
    end else begin
      rd_reg <= rd_next;
    end
  end

  // nominal frequency from band, coarse trim and fine trim
  always_comb begin
    logic [31:0] lo;
    logic [31:0] span;
    logic [31:0] est;
    lo   = span_lo(band_reg);
    span = span_hi(band_reg) - lo;
    est  = lo + ((span * 32'(coarse_reg)) >> `IBT_TRIM_SHIFT);
    if (fine_reg) begin
      est = est + (span >> `IBT_FINE_SHIFT);
    end
    freq_next = est[`IBT_FREQ_W-1:0];
    over_next = (est[`IBT_FREQ_W-1:0] > `IBT_LIMIT_KHZ);
  end

  // frequency estimate flops
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      freq_reg <= '0;
      over_reg <= 1'b0;
    end else begin
      freq_reg <= freq_next;
      over_reg <= over_next;
    end
  end

  // outputs, each from a flop
  assign o_rd_data              = rd_reg;
  assign o_osc_band_select      = band_reg;
  assign o_osc_coarse_trim      = coarse_reg;
  assign o_osc_fine_trim        = fine_reg;
  assign o_master_source_select = src_reg;
  assign o_master_tick          = clk_if.master_tick;
  assign o_divided_system_clock = clk_if.sys_tick;
  assign o_freq_est_khz         = freq_reg;
  assign o_over_limit           = over_reg;

endmodule

`default_nettype wire

//--- verification/ibt_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "ibt_consts.svh"

module ibt_top_properties
  import ibt_pkg::*;
(
  input wire logic                   i_core_clk,
  input wire logic                   i_arst_n,
  input wire logic [`IBT_ADDR_W-1:0] i_addr,
  input wire logic [`IBT_DATA_W-1:0] i_wr_data,
  input wire logic                   i_wr_stb,
  input wire logic                   i_rd_stb,
  input wire logic [`IBT_DATA_W-1:0] o_rd_data,
  input wire logic [`IBT_BAND_W-1:0] o_osc_band_select,
  input wire logic [`IBT_TRIM_W-1:0] o_osc_coarse_trim,
  input wire logic                   o_osc_fine_trim,
  input wire logic [`IBT_SRC_W-1:0]  o_master_source_select,
  input wire logic                   o_master_tick,
  input wire logic                   o_divided_system_clock,
  input wire logic [`IBT_FREQ_W-1:0] o_freq_est_khz
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);

  // read data only in the answer cycle
  rd_idle_zero_a: assert property (!$past(i_rd_stb)
    |-> o_rd_data == 8'h00)
    else $error("read data not zero outside answer");
  unmapped_read_a: assert property (i_rd_stb && !(i_addr inside
    {`IBT_ADDR_BAND, `IBT_ADDR_FINE, `IBT_ADDR_COARSE, `IBT_ADDR_SRC,
     `IBT_ADDR_DIV, `IBT_ADDR_STATUS}) |=> o_rd_data == 8'h00)
    else $error("unmapped read not zero");
  band_upper_a: assert property (i_rd_stb && i_addr == `IBT_ADDR_BAND
    |=> o_rd_data[7:2] == 6'h00) else $error("band upper bits set");
  band_read_a: assert property (i_rd_stb && i_addr == `IBT_ADDR_BAND
    |=> o_rd_data[1:0] == $past(o_osc_band_select))
    else $error("band read differs from band output");
  coarse_write_a: assert property (i_wr_stb
    && i_addr == `IBT_ADDR_COARSE |=> o_osc_coarse_trim == $past(i_wr_data))
    else $error("coarse trim write lost");
  fine_write_a: assert property (i_wr_stb && i_addr == `IBT_ADDR_FINE
    |=> o_osc_fine_trim == $past(i_wr_data[0]))
    else $error("fine trim write lost");
  src_write_a: assert property (i_wr_stb && i_addr == `IBT_ADDR_SRC
    |=> o_master_source_select == $past(i_wr_data[1:0]))
    else $error("source write lost");
  src_stop_a: assert property ((o_master_source_select == 2'h2)[*2]
    |-> !o_master_tick) else $error("tick on reserved source");
  hirc_tick_a: assert property ((o_master_source_select == 2'h0)[*4]
    |-> o_master_tick) else $error("internal source tick missing");
  sys_after_tick_a: assert property (o_divided_system_clock
    |-> $past(o_master_tick)) else $error("system pulse without tick");
  top_span_a: assert property ((o_osc_band_select == 2'h3)[*4]
    |-> o_freq_est_khz >= 16'h7148 && o_freq_est_khz <= 16'hD6D8)
    else $error("top band estimate out of span");
endmodule

bind ibt_top ibt_top_properties i_ibt_top_properties (
  .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_addr(i_addr),
  .i_wr_data(i_wr_data), .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb),
  .o_rd_data(o_rd_data), .o_osc_band_select(o_osc_band_select),
  .o_osc_coarse_trim(o_osc_coarse_trim), .o_osc_fine_trim(o_osc_fine_trim),
  .o_master_source_select(o_master_source_select),
  .o_master_tick(o_master_tick),
  .o_divided_system_clock(o_divided_system_clock),
  .o_freq_est_khz(o_freq_est_khz)
);

`default_nettype wire

//--- verification/test_ibt_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ibt_consts.svh"

module test_ibt_top;
  import ibt_pkg::*;
  logic            clk, arst_n, wr_stb, rd_stb, p_fine, xtal, lirc;
  logic            fine, tick, divided_system_clock, over, rd_pend;
  ibt_addr_t       addr;
  ibt_byte_t       wdata, rd_data, p_coarse, p_div, coarse, c;
  logic [1:0]      p_band, band, src;
  logic [15:0]     est_khz, e;
  ibt_byte_t       exp_q[$];
  ibt_addr_t       regs[4] = '{`IBT_ADDR_BAND, `IBT_ADDR_FINE,
                               `IBT_ADDR_COARSE, `IBT_ADDR_DIV};
  ibt_byte_t       msk[4] = '{8'h03, 8'h01, 8'hFF, 8'hFF};
  int              dv[6] = '{0, 1, 2, 3, 7, 255};
  int              num_errors, checks_done, cyc, ticks, sysn, last, gap;
  int              n, t0, s0;

  ibt_top i_ibt_top (
    .i_core_clk(clk), .i_arst_n(arst_n), .i_addr(addr),
    .i_wr_data(wdata), .i_wr_stb(wr_stb), .i_rd_stb(rd_stb),
    .o_rd_data(rd_data), .i_prog_band(p_band), .i_prog_coarse(p_coarse),
    .i_prog_fine(p_fine), .i_prog_div(p_div), .i_xtal_clk_pin(xtal),
    .i_lirc_clk_pin(lirc), .o_osc_band_select(band),
    .o_osc_coarse_trim(coarse), .o_osc_fine_trim(fine),
    .o_master_source_select(src), .o_master_tick(tick),
    .o_divided_system_clock(divided_system_clock), .o_freq_est_khz(est_khz),
    .o_over_limit(over)
  );

  task automatic check(input string nm, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("FAIL %s expected %0h seen %0h", nm, e, s);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // one bus cycle; for a read, d is the expected answer
  task automatic bus(input logic w, input ibt_addr_t a, input ibt_byte_t d);
    addr <= a;
    wdata <= d;
    wr_stb <= w;
    rd_stb <= !w;
    if (!w) exp_q.push_back(d);
    @(posedge clk);
  endtask

  task automatic idle(input int k);
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
    repeat (k) @(posedge clk);
  endtask

  // nominal estimate from band centre, trim span and trims
  function automatic logic [15:0] est(input int b, input int ct, input int f);
    longint ctr, lo, hi;
    ctr = (b == 0) ? `IBT_CTR_B0_KHZ : (b == 1) ? `IBT_CTR_B1_KHZ :
          (b == 2) ? `IBT_CTR_B2_KHZ : `IBT_CTR_B3_KHZ;
    lo = ctr * `IBT_SPAN_LO_KHZ / `IBT_CTR_B3_KHZ;
    hi = ctr * `IBT_SPAN_HI_KHZ / `IBT_CTR_B3_KHZ;
    return 16'(lo + (((hi - lo) * ct) >> 8) + (f != 0 ? (hi - lo) >> 9 : 0));
  endfunction

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // watcher: read answers, tick and pulse counts, timeout
  always @(posedge clk) begin
    rd_pend <= rd_stb;
    cyc <= cyc + 1;
    if (rd_pend) check("rd_data", rd_data, exp_q.pop_front());
    if (tick === 1'b1) ticks <= ticks + 1;
    if (divided_system_clock === 1'b1) begin
      sysn <= sysn + 1;
      gap <= cyc - last;
      last <= cyc;
    end
    if (cyc > 6000) begin
      num_errors++;
      give_verdict();
    end
  end

  initial begin
    void'($urandom(26451));
    arst_n = 1'b0;
    {wr_stb, rd_stb, xtal, lirc} = 4'h0;
    addr = 16'h0000;
    wdata = 8'h00;
    p_band = 2'($urandom);
    p_coarse = 8'($urandom);
    p_fine = 1'($urandom);
    p_div = 8'($urandom);
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    // stored values after reset
    bus(1'b0, `IBT_ADDR_BAND, {6'h00, p_band});
    bus(1'b0, `IBT_ADDR_FINE, {7'h00, p_fine});
    bus(1'b0, `IBT_ADDR_COARSE, p_coarse);
    bus(1'b0, `IBT_ADDR_DIV, p_div);
    check("band", band, p_band);
    // back to back write and read back
    for (int k = 0; k < 12; k++) begin
      c = 8'($urandom);
      bus(1'b1, regs[k % 4], c);
      bus(1'b0, regs[k % 4], c & msk[k % 4]);
    end
    // every band with trim corners
    for (int b = 0; b < 4; b++) begin
      for (int k = 0; k < 6; k++) begin
        c = (k < 2) ? 8'h00 : (k < 4) ? 8'hFF : 8'($urandom);
        bus(1'b1, `IBT_ADDR_BAND, 8'(b));
        bus(1'b1, `IBT_ADDR_COARSE, c);
        bus(1'b1, `IBT_ADDR_FINE, 8'(k % 2));
        idle(3);
        e = est(b, c, k % 2);
        check("est", est_khz, e);
        check("over", over, e > `IBT_LIMIT_KHZ);
        check("coarse", coarse, c);
      end
    end
    // divider values, 0 and 1 mean no division
    foreach (dv[i]) begin
      bus(1'b1, `IBT_ADDR_DIV, 8'(dv[i]));
      n = (dv[i] < 2) ? 1 : dv[i];
      idle(2 * n + 4);
      check("gap", gap, n);
    end
    // external and low-speed sources, reserved code stops ticks
    for (int s = 1; s < 4; s++) begin
      bus(1'b1, `IBT_ADDR_DIV, 8'h01);
      bus(1'b1, `IBT_ADDR_SRC, 8'(s));
      idle(6);
      t0 = ticks;
      s0 = sysn;
      for (int j = 0; j < 5; j++) begin
        xtal <= 1'b1;
        lirc <= (j < 3);
        repeat (4) @(posedge clk);
        xtal <= 1'b0;
        lirc <= 1'b0;
        repeat (4) @(posedge clk);
      end
      idle(8);
      n = (s == 1) ? 5 : (s == 3) ? 3 : 0;
      check("ticks", ticks - t0, n);
      check("divided_system_clock", sysn - s0, n);
    end
    // reserved source freezes the divided level for the status read
    bus(1'b1, `IBT_ADDR_SRC, 8'h02);
    // unmapped and status writes are ignored
    bus(1'b1, 16'hFE02, 8'hA5);
    bus(1'b1, `IBT_ADDR_STATUS, 8'hFF);
    bus(1'b0, 16'hFE02, 8'h00);
    bus(1'b0, 16'hFFFF, 8'h00);
    bus(1'b0, `IBT_ADDR_STATUS, {5'h00, 1'(sysn), e > `IBT_LIMIT_KHZ, 1'b1});
    bus(1'b0, `IBT_ADDR_COARSE, c);
    idle(3);
    // second reset in mid-run reloads the stored values
    p_coarse <= 8'($urandom);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    bus(1'b0, `IBT_ADDR_COARSE, p_coarse);
    idle(3);
    check("src", src, 2'h0);
    check("queue", exp_q.size(), 0);
    give_verdict();
  end
endmodule

`default_nettype wire
